/* File: hw/bfs_sequencer.sv */
// Fault protection and power-good sequencer of a synchronous buck stage.
//
// Behaviour
// - In skip mode, zero-crossing turns the low-side FET off.
// - Low-side stays on while its current exceeds the valley limit.
// - Undervoltage held for the 68 us delay shuts down into hiccup.
// - Hiccup sleeps about 14 ms, then starts a fresh soft start.
// - Undervoltage detection is armed after soft start completes, and in overvoltage.
// - Valley limit works during start-up; undervoltage limit_set_pin waits for it.
// - Undervoltage delay counter clears when feedback recovers.
// - Overvoltage latches high-side off and turns the low-side on.
// - In overvoltage, negative limit gives one high-side on-time, repeating.
// - Overvoltage cycling ends after 68 us undervoltage; both FETs latch off.
// - Overvoltage latch clears only by enable toggle or supply reset.
// - Negative limit: low-side off, high-side one on-time, low-side again.
// - Power-good rises 1.06 ms after internal and external soft start.
// - Internal soft start takes 2 ms before it counts as done.
// - External soft-start flag sets when feedback reaches reference less 50 mV.
// - Feedback outside window for 2 us latches power-good low.
// - Latched-low power-good clears only by enable toggle or supply reset.
// - Power-good sits low by default; monitoring starts after soft start.
// - A fixed clamp bounds the valley limit when the limit pin is shorted.
// - Light-load mode is caught during power-on delay, then frozen.
`timescale 1ns/1ps
module bfs_sequencer
    import bfs_pkg::*;
#(
    parameter int HICCUP_TC = HICCUP_TICKS,
    parameter int SS_TC     = SS_TICKS,
    parameter int PG_TC     = PG_TICKS,
    parameter int POR_TC    = POR_TICKS
) (
    input  wire logic sys_clk_in,
    input  wire logic nrst_in,
    input  wire logic en_in,
    input  wire logic bias_valid_in,
    input  wire logic mode_forced_continuous_mode_in,
    input  wire logic limit_short_in,
    input  wire logic uv_cmp_in,
    input  wire logic ov_cmp_in,
    input  wire logic valley_oc_in,
    input  wire logic clamp_oc_in,
    input  wire logic neg_limit_in,
    input  wire logic zero_cross_in,
    input  wire logic ext_ss_cmp_in,
    input  wire logic pwm_request_in,
    input  wire logic ontime_done_in,
    output logic      hs_gate_out,
    output logic      ls_gate_out,
    output logic      power_good_out,
    output logic      power_good_oe_out,
    output logic      soft_start_out,
    output logic      hiccup_out,
    output logic      ov_latched_out,
    output logic      skip_mode_out
);

    // Timer counts must fit the timer and stay above zero.
    if (HICCUP_TC < 1 || HICCUP_TC >= (1 << TMR_W) ||
        SS_TC < 1 || SS_TC >= (1 << TMR_W) ||
        PG_TC < 1 || PG_TC >= (1 << TMR_W) ||
        POR_TC < 1 || POR_TC >= (1 << TMR_W)) begin : g_bad_param
        $error("bfs_sequencer: timer count out of range");
    end

    localparam logic [TMR_W-1:0] UV_TC  = TMR_W'(UV_TICKS);
    localparam logic [TMR_W-1:0] PGF_TC = TMR_W'(PGF_TICKS);
    localparam logic [TMR_W-1:0] HIC_TC = TMR_W'(HICCUP_TC);
    localparam logic [TMR_W-1:0] SST_TC = TMR_W'(SS_TC);
    localparam logic [TMR_W-1:0] PGD_TC = TMR_W'(PG_TC);
    localparam logic [TMR_W-1:0] PON_TC = TMR_W'(POR_TC);
    localparam logic [TICK_W-1:0] TICK_TC = TICK_W'(TICK_CYC - 1);

    logic [IN_W-1:0]   raw;
    logic [IN_W-1:0]   s;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick_reg;
    bfs_state_e        state_reg;
    bfs_state_e        state_next;
    logic [TMR_W-1:0]  tmr_reg;
    logic [TMR_W-1:0]  uv_cnt_reg;
    logic              uv_expired;
    bfs_phase_e        phase_reg;
    bfs_phase_e        phase_next;
    logic              switching_next;
    logic              oc_eff;
    logic              skip_mode_reg;
    logic              ext_done_reg;
    logic [TMR_W-1:0]  pg_dly_reg;
    logic [TMR_W-1:0]  pg_flt_reg;
    logic              pg_latch_reg;
    logic              pg_good_next;

    // Gather the asynchronous inputs into one bundle.
    assign raw[IN_EN]    = en_in;
    assign raw[IN_BIAS]  = bias_valid_in;
    assign raw[IN_FORCED_CONTINUOUS_MODE]  = mode_forced_continuous_mode_in;
    assign raw[IN_SHORT] = limit_short_in;
    assign raw[IN_UV]    = uv_cmp_in;
    assign raw[IN_OV]    = ov_cmp_in;
    assign raw[IN_OC]    = valley_oc_in;
    assign raw[IN_CLAMP] = clamp_oc_in;
    assign raw[IN_NEG]   = neg_limit_in;
    assign raw[IN_ZC]    = zero_cross_in;
    assign raw[IN_EXT]   = ext_ss_cmp_in;
    assign raw[IN_PWM]   = pwm_request_in;
    assign raw[IN_TON]   = ontime_done_in;

    // Every pin but the clock and reset passes the synchroniser before any logic sees it.
    bfs_sync #(
        .WIDTH (IN_W)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .async_in   (raw),
        .sync_out   (s)
    );

    // Microsecond timebase shared by every delay.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_TC) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg     <= 1'b0;
        end
    end

    // Undervoltage delay counter, armed only in the run and overvoltage states.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            uv_cnt_reg <= '0;
        end else if (!s[IN_UV] ||
                     (state_reg != ST_RUN && state_reg != ST_OV)) begin
            uv_cnt_reg <= '0;
        end else if (tick_reg && !uv_expired) begin
            uv_cnt_reg <= uv_cnt_reg + 1'b1;
        end
    end
    assign uv_expired = (uv_cnt_reg >= UV_TC);

    // Sequencer state transitions.
    always_comb begin
        state_next = state_reg;
        if (!s[IN_EN] || !s[IN_BIAS]) begin
            state_next = ST_OFF;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    state_next = ST_POR;
                end
                ST_POR: begin
                    if (tmr_reg >= PON_TC) begin
                        state_next = ST_SOFT;
                    end
                end
                ST_SOFT: begin
                    if (s[IN_OV]) begin
                        state_next = ST_OV;
                    end else if (tmr_reg >= SST_TC) begin
                        state_next = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (s[IN_OV]) begin
                        state_next = ST_OV;
                    end else if (uv_expired) begin
                        state_next = ST_HICCUP;
                    end
                end
                ST_HICCUP: begin
                    if (tmr_reg >= HIC_TC) begin
                        state_next = ST_SOFT;
                    end
                end
                ST_OV: begin
                    if (uv_expired) begin
                        state_next = ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    state_next = ST_LATCH;
                end
                default: begin
                    state_next = ST_OFF;
                end
            endcase
        end
    end

    // State register and its dwell timer, which restarts on each change.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_reg <= ST_OFF;
            tmr_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                tmr_reg <= '0;
            end else if (tick_reg && tmr_reg != '1) begin
                tmr_reg <= tmr_reg + 1'b1;
            end
        end
    end

    // Light-load mode is sampled only during the power-on delay.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            skip_mode_reg <= 1'b1;
        end else if (state_reg == ST_POR) begin
            skip_mode_reg <= !s[IN_FORCED_CONTINUOUS_MODE];
        end
    end

    // A shorted limit pin hands the valley limit to the fixed clamp.
    assign oc_eff = s[IN_SHORT] ? s[IN_CLAMP] : s[IN_OC];

    // Switching phase of the power stage.
    always_comb begin
        switching_next = (state_next == ST_SOFT) || (state_next == ST_RUN) ||
                         (state_next == ST_OV);
        phase_next = phase_reg;
        case (phase_reg)
            PH_IDLE: begin
                if (state_next == ST_OV) begin
                    phase_next = PH_LS;
                end else if (s[IN_PWM]) begin
                    phase_next = PH_HS;
                end
            end
            PH_HS: begin
                if (s[IN_TON]) begin
                    phase_next = PH_LS;
                end
            end
            PH_LS: begin
                if (s[IN_NEG]) begin
                    phase_next = PH_HS;
                end else if (state_next == ST_OV) begin
                    phase_next = PH_LS;
                end else if (oc_eff) begin
                    phase_next = PH_LS;
                end else if (skip_mode_reg && s[IN_ZC]) begin
                    phase_next = PH_IDLE;
                end else if (s[IN_PWM]) begin
                    phase_next = PH_HS;
                end
            end
            default: begin
                phase_next = PH_IDLE;
            end
        endcase
        if (!switching_next) begin
            phase_next = PH_IDLE;
        end
    end

    // Phase register and registered gate enables.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            phase_reg   <= PH_IDLE;
            hs_gate_out <= 1'b0;
            ls_gate_out <= 1'b0;
        end else begin
            phase_reg   <= phase_next;
            hs_gate_out <= (phase_next == PH_HS);
            ls_gate_out <= (phase_next == PH_LS);
        end
    end

    // External soft-start done flag, held until the next start attempt.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            ext_done_reg <= 1'b0;
        end else if (state_reg == ST_OFF || state_reg == ST_HICCUP) begin
            ext_done_reg <= 1'b0;
        end else if (s[IN_EXT]) begin
            ext_done_reg <= 1'b1;
        end
    end

    // Power-good delay after both soft starts have finished.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            pg_dly_reg <= '0;
        end else if (state_reg != ST_RUN || !ext_done_reg) begin
            pg_dly_reg <= '0;
        end else if (tick_reg && pg_dly_reg < PGD_TC) begin
            pg_dly_reg <= pg_dly_reg + 1'b1;
        end
    end

    // Window fault filter and power-good latch; enable low clears it.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            pg_flt_reg   <= '0;
            pg_latch_reg <= 1'b0;
        end else if (state_reg == ST_OFF) begin
            pg_flt_reg   <= '0;
            pg_latch_reg <= 1'b0;
        end else if ((state_reg != ST_RUN && state_reg != ST_OV) ||
                     !(s[IN_UV] || s[IN_OV])) begin
            pg_flt_reg <= '0;
        end else if (pg_flt_reg >= PGF_TC) begin
            pg_latch_reg <= 1'b1;
        end else if (tick_reg) begin
            pg_flt_reg <= pg_flt_reg + 1'b1;
        end
    end

    assign pg_good_next = (state_next == ST_RUN) && ext_done_reg &&
                          !pg_latch_reg && (pg_dly_reg >= PGD_TC);

    // Open-drain power-good and status outputs, all registered.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            power_good_out    <= 1'b0;
            power_good_oe_out <= 1'b1;
            soft_start_out    <= 1'b0;
            hiccup_out        <= 1'b0;
            ov_latched_out    <= 1'b0;
            skip_mode_out     <= 1'b1;
        end else begin
            power_good_out    <= pg_good_next;
            power_good_oe_out <= !pg_good_next;
            soft_start_out    <= (state_next == ST_SOFT);
            hiccup_out        <= (state_next == ST_HICCUP);
            ov_latched_out    <= (state_next == ST_LATCH);
            skip_mode_out     <= skip_mode_reg;
        end
    end

    // Checks on the sequencing and the power stage.
    a_gates_exclusive: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !(hs_gate_out && ls_gate_out))
        else $error("both gates enabled");

    a_uv_disarmed: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        state_reg == ST_SOFT |-> uv_cnt_reg == '0)
        else $error("undervoltage counted during soft start");

    a_uv_clear: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !s[IN_UV] |=> uv_cnt_reg == '0)
        else $error("undervoltage counter not cleared");

    a_uv_to_hiccup: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        state_reg == ST_RUN && uv_expired && !s[IN_OV] && s[IN_EN] &&
        s[IN_BIAS] |=> state_reg == ST_HICCUP ##1 hiccup_out)
        else $error("undervoltage did not enter hiccup");

    a_hiccup_off: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        state_reg == ST_HICCUP && $past(state_reg) == ST_HICCUP |->
        !hs_gate_out && !ls_gate_out)
        else $error("switching during hiccup");

    a_latch_hold: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        state_reg == ST_LATCH && s[IN_EN] && s[IN_BIAS] |=>
        state_reg == ST_LATCH ##1 !hs_gate_out && !ls_gate_out)
        else $error("overvoltage latch released");

    a_neg_to_hs: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        phase_reg == PH_LS && s[IN_NEG] && switching_next |=>
        hs_gate_out && phase_reg == PH_HS)
        else $error("negative limit did not hand over to high side");

    a_mode_frozen: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        state_reg != ST_POR |=> $stable(skip_mode_reg))
        else $error("mode changed after power-on delay");

    a_pg_causes: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        power_good_out |-> ext_done_reg && state_reg == ST_RUN &&
        pg_dly_reg >= PGD_TC && !power_good_oe_out)
        else $error("power good without its conditions");

    a_pg_latched: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        pg_latch_reg && state_reg != ST_OFF |=> !power_good_out)
        else $error("power good high while latched low");

    a_skip_zc: assert property (
        @(posedge sys_clk_in) disable iff (!nrst_in)
        phase_reg == PH_LS && skip_mode_reg && s[IN_ZC] && !s[IN_NEG] &&
        !oc_eff && state_next == ST_RUN |=> !ls_gate_out)
        else $error("low side left on after zero crossing");

endmodule // bfs_sequencer

/* File: pkg/bfs_pkg.sv */
// Constants, timing figures and state codes of the buck fault sequencer.
package bfs_pkg;

    // System clock rate and the one-microsecond timebase derived from it.
    localparam int CLK_KHZ  = 25000;
    localparam int TICK_NS  = 1000;
    localparam int TICK_CYC = CLK_KHZ * TICK_NS / 1000000;
    localparam int TICK_W   = 5;

    // Delay figures in their own unit.
    localparam int UV_DELAY_NS  = 68000;
    localparam int HICCUP_NS    = 14000000;
    localparam int SS_NS        = 2000000;
    localparam int PG_DELAY_NS  = 1060000;
    localparam int PG_FAULT_NS  = 2000;
    localparam int POR_DELAY_NS = 100000;

    // Timer width in bits; the timers count timebase ticks.
    localparam int TMR_W = 15;

    // Ticks to wait so a delay is never shorter than nominal; one extra
    // tick covers the unknown phase of the timebase at the start.
    function automatic int ticks_for(input int ns);
        ticks_for = (ns + TICK_NS - 1) / TICK_NS + 1;
    endfunction

    localparam int UV_TICKS     = ticks_for(UV_DELAY_NS);
    localparam int HICCUP_TICKS = ticks_for(HICCUP_NS);
    localparam int SS_TICKS     = ticks_for(SS_NS);
    localparam int PG_TICKS     = ticks_for(PG_DELAY_NS);
    localparam int PGF_TICKS    = ticks_for(PG_FAULT_NS);
    localparam int POR_TICKS    = ticks_for(POR_DELAY_NS);

    // Bit positions of the synchronised input bundle.
    localparam int IN_EN    = 0;
    localparam int IN_BIAS  = 1;
    localparam int IN_FORCED_CONTINUOUS_MODE  = 2;
    localparam int IN_SHORT = 3;
    localparam int IN_UV    = 4;
    localparam int IN_OV    = 5;
    localparam int IN_OC    = 6;
    localparam int IN_CLAMP = 7;
    localparam int IN_NEG   = 8;
    localparam int IN_ZC    = 9;
    localparam int IN_EXT   = 10;
    localparam int IN_PWM   = 11;
    localparam int IN_TON   = 12;
    localparam int IN_W     = 13;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_OFF    = 3'h0,
        ST_POR    = 3'h1,
        ST_SOFT   = 3'h2,
        ST_RUN    = 3'h3,
        ST_HICCUP = 3'h4,
        ST_OV     = 3'h5,
        ST_LATCH  = 3'h6
    } bfs_state_e;

    // Switching phase of the power stage.
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_HS   = 2'h1,
        PH_LS   = 2'h2
    } bfs_phase_e;

endpackage

/* File: hw/bfs_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module bfs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            sync_out <= '0;
        end else begin
            s1_reg   <= async_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            sync_out <= (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));
        end
    end
endmodule // bfs_sync

/* File: test/bfs_far_side.sv */
// Far-side model: on-time timer and negative current sense of the stage.
`timescale 1ns/1ps
module bfs_far_side #(
    parameter int ONT_CYC = 15,
    parameter int NEG_CYC = 20
) (
    input  wire logic sys_clk_in,
    input  wire logic hs_gate_in,
    input  wire logic ls_gate_in,
    input  wire logic neg_drive_in,
    output logic      ontime_done_out,
    output logic      neg_limit_out
);
    int hs_cnt = 0;
    int ls_cnt = 0;

    // Both comparators start quiet so the block sees no stray fault.
    initial begin
        ontime_done_out = 1'b0;
        neg_limit_out = 1'b0;
    end

    // The on-time ends a fixed time after the high-side turns on and holds
    // until it turns off; current only swings negative when the bench
    // asks for it, a fixed time into each low-side interval.
    always @(negedge sys_clk_in) begin
        hs_cnt = hs_gate_in ? hs_cnt + 1 : 0;
        ls_cnt = ls_gate_in ? ls_cnt + 1 : 0;
        ontime_done_out <= (hs_cnt >= ONT_CYC);
        neg_limit_out <= neg_drive_in && (ls_cnt >= NEG_CYC);
    end
endmodule // bfs_far_side

/* File: test/tb.sv */
// Self-checking bench for the buck fault and power-good sequencer.
`timescale 1ns/1ps
module tb;
    import bfs_pkg::*;
    localparam int SS_T  = 4;
    localparam int PG_T  = 5;
    localparam int HC_T  = 6;
    localparam int POR_T = 3;
    localparam int TK    = TICK_CYC;
    logic sys_clk, nrst, en, forced_continuous_mode, lshort, uv, ov, voc, coc, zc, ext_ss;
    logic pwm, neg_drive, ont_done, neg_lim, bias;
    logic hs, ls, pg, pg_oe, ss, hic, ovl, skip;
    int   n_fail = 0;
    int   samples_checked = 0;
    int   c;

    // Small delay counts keep the run short.
    bfs_sequencer #(.HICCUP_TC(HC_T), .SS_TC(SS_T), .PG_TC(PG_T),
                    .POR_TC(POR_T)) bfs_sequencer_i (
        .sys_clk_in(sys_clk), .nrst_in(nrst), .en_in(en),
        .bias_valid_in(bias), .mode_forced_continuous_mode_in(forced_continuous_mode),
        .limit_short_in(lshort), .uv_cmp_in(uv), .ov_cmp_in(ov),
        .valley_oc_in(voc), .clamp_oc_in(coc), .neg_limit_in(neg_lim),
        .zero_cross_in(zc), .ext_ss_cmp_in(ext_ss),
        .pwm_request_in(pwm), .ontime_done_in(ont_done),
        .hs_gate_out(hs), .ls_gate_out(ls), .power_good_out(pg),
        .power_good_oe_out(pg_oe), .soft_start_out(ss),
        .hiccup_out(hic), .ov_latched_out(ovl), .skip_mode_out(skip));

    bfs_far_side bfs_far_side_i (
        .sys_clk_in(sys_clk), .hs_gate_in(hs), .ls_gate_in(ls),
        .neg_drive_in(neg_drive), .ontime_done_out(ont_done),
        .neg_limit_out(neg_lim));

    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Counts one comparison and reports a mismatch.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares a measured cycle count against a window.
    task automatic check_rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: pick = hs;
            1: pick = ls;
            2: pick = pg;
            3: pick = ss;
            4: pick = hic;
            default: pick = ovl;
        endcase
    endfunction

    // Counts falling edges until an output takes a value, up to a limit.
    task automatic wait_val(input int k, input logic v, input int lim,
                            output int cyc);
        cyc = 0;
        while (pick(k) !== v && cyc < lim) begin
            @(negedge sys_clk);
            cyc++;
        end
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One high-side pulse ending in the low-side phase.
    task automatic to_ls;
        pwm = 1'b1;
        wait_val(0, 1'b1, 12, c);
        pwm = 1'b0;
        wait_val(1, 1'b1, 40, c);
        check(hs, 1'b0);
    endtask

    // Zero crossing in skip mode ends the low-side phase.
    task automatic zc_off;
        zc = 1'b1;
        wait_val(1, 1'b0, 10, c);
        check_rng(c, 1, 8);
        zc = 1'b0;
        cyc_n(6);
    endtask

    task automatic t_start;
        en = 1'b1;
        wait_val(3, 1'b1, (POR_T + 3) * TK, c);
        forced_continuous_mode = 1'b1;
        wait_val(3, 1'b0, (SS_T + 3) * TK, c);
        check_rng(c, (SS_T - 1) * TK, (SS_T + 1) * TK + 8);
        cyc_n(2 * PG_T * TK);
        check(pg, 1'b0);
        ext_ss = 1'b1;
        wait_val(2, 1'b1, (PG_T + 3) * TK, c);
        check_rng(c, (PG_T - 1) * TK, (PG_T + 1) * TK + 8);
        check(pg_oe, 1'b0);
        check(skip, 1'b1);
        forced_continuous_mode = 1'b0;
    endtask

    task automatic t_switch;
        to_ls();
        cyc_n(30);
        check(ls, 1'b1);
        zc_off();
        to_ls();
        voc = 1'b1;
        cyc_n(6);
        pwm = 1'b1;
        cyc_n(30);
        check({hs, ls}, 2'b01);
        voc = 1'b0;
        wait_val(0, 1'b1, 12, c);
        check_rng(c, 1, 10);
        pwm = 1'b0;
        wait_val(1, 1'b1, 40, c);
        lshort = 1'b1;
        coc = 1'b1;
        pwm = 1'b1;
        cyc_n(30);
        check({hs, ls}, 2'b01);
        coc = 1'b0;
        wait_val(0, 1'b1, 12, c);
        check_rng(c, 1, 10);
        pwm = 1'b0;
        lshort = 1'b0;
        wait_val(1, 1'b1, 40, c);
        zc_off();
    endtask

    task automatic t_uv;
        uv = 1'b1;
        wait_val(2, 1'b0, 6 * TK, c);
        check_rng(c, 2 * TK, 4 * TK + 8);
        cyc_n(40 * TK);
        uv = 1'b0;
        cyc_n(40 * TK);
        check({hic, pg}, 2'b00);
        uv = 1'b1;
        wait_val(4, 1'b1, 75 * TK, c);
        check_rng(c, 68 * TK, 70 * TK + 8);
        check({hs, ls}, 2'b00);
        wait_val(4, 1'b0, (HC_T + 3) * TK, c);
        check_rng(c, (HC_T - 1) * TK, (HC_T + 1) * TK + 8);
        wait_val(3, 1'b1, 30, c);
        check_rng(c, 0, 29);
        wait_val(3, 1'b0, (SS_T + 3) * TK, c);
        wait_val(4, 1'b1, 75 * TK, c);
        check_rng(c, 68 * TK, 70 * TK + 8);
        uv = 1'b0;
        en = 1'b0;
        cyc_n(10);
        en = 1'b1;
        wait_val(2, 1'b1, (POR_T + SS_T + PG_T + 9) * TK, c);
        check(pg, 1'b1);
    endtask

    task automatic t_ov;
        neg_drive = 1'b1;
        ov = 1'b1;
        wait_val(1, 1'b1, 10, c);
        check_rng(c, 1, 8);
        check(hs, 1'b0);
        repeat (2) begin
            wait_val(0, 1'b1, 60, c);
            check_rng(c, 1, 59);
            wait_val(1, 1'b1, 40, c);
            check_rng(c, 1, 39);
        end
        check(pg, 1'b0);
        ov = 1'b0;
        uv = 1'b1;
        wait_val(5, 1'b1, 75 * TK, c);
        check_rng(c, 68 * TK, 70 * TK + 8);
        check({hs, ls}, 2'b00);
        uv = 1'b0;
        neg_drive = 1'b0;
        cyc_n(2 * TK);
        check({ovl, hs, ls}, 3'b100);
        en = 1'b0;
        wait_val(5, 1'b0, 10, c);
        check_rng(c, 1, 9);
        en = 1'b1;
    endtask

    // Bias loss drops the stage to its default: power-good pulled low.
    task automatic t_bias;
        cyc_n(4 * TK);
        bias = 1'b0;
        cyc_n(10);
        check({pg, pg_oe, ss, hs, ls}, 5'h08);
        bias = 1'b1;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reset, power-up defaults, then the scenarios in turn.
    initial begin
        {nrst, en, forced_continuous_mode, lshort, uv, ov, voc, coc} = 8'h00;
        {zc, ext_ss, pwm, neg_drive} = 4'h0;
        bias = 1'b1;
        cyc_n(3);
        check({hs, ls, pg, pg_oe, skip}, 5'h03);
        nrst = 1'b1;
        t_start();
        t_switch();
        t_uv();
        t_ov();
        t_bias();
        give_verdict();
    end

    // A hung wait ends the run as a failure.
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_fail++;
        give_verdict();
    end
endmodule // tb
